// ===== hw/pt32_top.sv
// paired 16/32-bit timers: two pairs, four 16-bit halves
// Behaviour
// RULE1 - pair runs joined 32-bit or split
// RULE2 - split halves: all modes but asynchronous counting
// RULE3 - joined: 32-bit timer or synchronous counter
// RULE4 - each half: synchronous timer or counter
// RULE5 - lower half low word, upper high
// RULE6 - joined: only lower control bits used
// RULE7 - joined: clock and gate from lower
// RULE8 - 32-bit match event on upper flag
// RULE9 - gate and prescaler in every configuration; gate is ignored here with external clock
// RULE10 - timers keep running in idle, sleep; here a timer stops in idle when its ctl_stop_idle bit is set, or the lower half's bit when joined
// RULE11 - counts and ticks serve capture/compare
// RULE12 - converter trigger only from joined pair one
// RULE13 - all four timers can request DMA
// RULE14 - period match returns count to zero
// RULE15 - count one per tick while gate permits
`timescale 1ns/1ps
module pt32_top
   import pt32_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic idle,
   input wire logic [3:0] ctl_on,
   input wire logic [3:0] ctl_gated,
   input wire logic [3:0] ctl_ext,
   input wire logic [3:0] ctl_join,
   input wire logic [3:0] ctl_stop_idle,
   input wire logic [7:0] ctl_ps,
   input wire logic [63:0] period,
   input wire logic [3:0] ext_clk_pin,
   input wire logic [3:0] gate_pin,
   output logic [63:0] count,
   output logic [3:0] period_evt,
   output logic [3:0] dma_req,
   output logic adc_trig,
   output logic [3:0] tb_tick
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rst_sync;
   wire logic rst_n;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   assign rst_n = rst_sync[1];

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [3:0] clk_s1;
   logic [3:0] clk_s2;
   logic [3:0] clk_s3;
   logic [3:0] gate_s1;
   logic [3:0] gate_s2;
   wire logic [3:0] clk_rise;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_s1 <= 4'h0;
         clk_s2 <= 4'h0;
         clk_s3 <= 4'h0;
         gate_s1 <= 4'h0;
         gate_s2 <= 4'h0;
      end else begin
         clk_s1 <= ext_clk_pin;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         gate_s1 <= gate_pin;
         gate_s2 <= gate_s1;
      end
   end

   // RULE2 no asynchronous counter
   // RULE4 synchronous counting only
   // edge taken after two stages, so no asynchronous counter path exists
   assign clk_rise = clk_s2 & ~clk_s3;

   // ----------------------------------------
   // per-pair join and 32-bit match
   // ----------------------------------------
   wire logic [1:0] joined;
   wire logic [3:0] tick;
   wire logic [3:0] match16;
   wire logic [1:0] match32;
   wire logic [1:0] lo_full;
   logic [15:0] cnt_q [PT32_NUM];

   // RULE1 join selected by lower control
   // RULE6 upper join bit ignored
   assign joined[0] = ctl_join[PT32_P1_LO];
   assign joined[1] = ctl_join[PT32_P2_LO];

   genvar i;
   generate
      for (i = 0; i < PT32_NUM; i++) begin : g_tmr
         localparam int LO = i - (i % 2);
         localparam int PR = i / 2;
         wire logic sel_lo;
         wire logic src_on;
         wire logic src_gated;
         wire logic src_ext;
         wire logic src_stop;
         wire logic src_gate;
         wire logic src_rise;
         wire logic [1:0] src_ps;
         wire logic run;
         pt32_cnt_if cif ();

         // RULE6 joined upper takes lower controls
         assign sel_lo = joined[PR] && (i % 2 == 1);
         assign src_on = sel_lo ? ctl_on[LO] : ctl_on[i];
         assign src_gated = sel_lo ? ctl_gated[LO] : ctl_gated[i];
         assign src_ext = sel_lo ? ctl_ext[LO] : ctl_ext[i];
         assign src_stop = sel_lo ? ctl_stop_idle[LO] : ctl_stop_idle[i];
         assign src_ps = sel_lo ? ctl_ps[2*LO +: 2] : ctl_ps[2*i +: 2];
         // RULE7 joined clock and gate from lower pins
         assign src_gate = sel_lo ? gate_s2[LO] : gate_s2[i];
         assign src_rise = sel_lo ? clk_rise[LO] : clk_rise[i];

         // RULE10 runs through idle unless told to stop
         // sleep has no effect here: the count clock is kept alive
         assign run = src_on && !(idle && src_stop);

         // RULE9 gate and prescaler per timer
         // RULE15 tick only while gate permits
         pt32_prescale u_ps (
            .clk(clk),
            .rst_n(rst_n),
            .run(run),
            .ext_src(src_ext),
            .gated(src_gated && !src_ext),
            .gate_lvl(src_gate),
            .ext_rise(src_rise),
            .ps_sel(src_ps),
            .tick(tick[i])
         );

         assign match16[i] = (cnt_q[i] == period[16*i +: 16]);

         if (i % 2 == 0) begin : g_lo
            // RULE14 wrap to zero on match
            // RULE3 joined lower wraps on full 32-bit match
            assign cif.inc = tick[i];
            assign cif.wrap = joined[PR] ? match32[PR] : match16[i];
            // RULE8 joined lower reports nothing
            assign cif.report = !joined[PR];
         end else begin : g_hi
            // RULE5 upper carries from lower full word
            assign cif.inc = joined[PR] ? (tick[LO] && (match32[PR] || lo_full[PR])) : tick[i];
            assign cif.wrap = joined[PR] ? match32[PR] : match16[i];
            // RULE8 upper flag reports 32-bit match
            assign cif.report = 1'b1;
         end

         pt32_count u_cnt (
            .clk(clk),
            .rst_n(rst_n),
            .cif(cif)
         );

         assign cnt_q[i] = cif.count;
         // RULE5 lower half low word of count
         assign count[16*i +: 16] = cif.count;
         assign period_evt[i] = cif.evt;
      end
   endgenerate

   // RULE5 32-bit compare across both halves
   assign match32[0] = match16[PT32_P1_LO] && match16[PT32_P1_HI];
   assign match32[1] = match16[PT32_P2_LO] && match16[PT32_P2_HI];
   assign lo_full[0] = (cnt_q[PT32_P1_LO] == PT32_COUNT_TOP);
   assign lo_full[1] = (cnt_q[PT32_P2_LO] == PT32_COUNT_TOP);

   // ----------------------------------------
   // triggers toward capture, compare, DMA, converter
   // ----------------------------------------
   logic join1_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         join1_q <= 1'b0;
         tb_tick <= 4'h0;
      end else begin
         join1_q <= joined[0];
         // RULE11 time base ticks for capture/compare
         tb_tick <= tick;
      end
   end

   // RULE13 every half may request a DMA transfer
   assign dma_req = period_evt;
   // RULE12 converter trigger from joined pair one only
   // join is delayed to line up with the registered event
   assign adc_trig = period_evt[PT32_P1_HI] && join1_q;

endmodule

// ===== common/pt32_pkg.sv
// constants and helpers shared by the paired 32-bit timer block
package pt32_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int PT32_NUM = 4;
   localparam int PT32_CW = 16;
   localparam int PT32_PSW = 8;

   // ----------------------------------------
   // timer indices: pair 1 lower/upper, pair 2 lower/upper
   // ----------------------------------------
   localparam int PT32_P1_LO = 0;
   localparam int PT32_P1_HI = 1;
   localparam int PT32_P2_LO = 2;
   localparam int PT32_P2_HI = 3;

   // ----------------------------------------
   // reset values and terminal values
   // ----------------------------------------
   localparam logic [PT32_CW-1:0] PT32_COUNT_RST = 16'h0000;
   localparam logic [PT32_CW-1:0] PT32_COUNT_TOP = 16'hFFFF;
   localparam logic [PT32_PSW-1:0] PT32_PS_RST = 8'h00;

   // ----------------------------------------
   // prescaler terminal counts (divide by 1, 8, 64, 256)
   // ----------------------------------------
   localparam logic [1:0] PT32_PS_SEL1 = 2'h0;
   localparam logic [1:0] PT32_PS_SEL8 = 2'h1;
   localparam logic [1:0] PT32_PS_SEL64 = 2'h2;
   localparam logic [PT32_PSW-1:0] PT32_PS_LIM1 = 8'h00;
   localparam logic [PT32_PSW-1:0] PT32_PS_LIM8 = 8'h07;
   localparam logic [PT32_PSW-1:0] PT32_PS_LIM64 = 8'h3F;
   localparam logic [PT32_PSW-1:0] PT32_PS_LIM256 = 8'hFF;

   function automatic logic [PT32_PSW-1:0] pt32_ps_limit(input logic [1:0] sel);
      logic [PT32_PSW-1:0] lim;
      lim = PT32_PS_LIM256;
      if (sel == PT32_PS_SEL1) begin
         lim = PT32_PS_LIM1;
      end else if (sel == PT32_PS_SEL8) begin
         lim = PT32_PS_LIM8;
      end else if (sel == PT32_PS_SEL64) begin
         lim = PT32_PS_LIM64;
      end
      return lim;
   endfunction

endpackage

// ===== common/pt32_cnt_if.sv
// count control carrier between the timer top and one 16-bit count half
`timescale 1ns/1ps
interface pt32_cnt_if;
   logic inc;
   logic wrap;
   logic report;
   logic [15:0] count;
   logic evt;
   modport ctl (output inc, output wrap, output report, input count, input evt);
   modport cnt (input inc, input wrap, input report, output count, output evt);
endinterface

// ===== hw/pt32_prescale.sv
// clock source select, gate and prescaler for one 16-bit timer
`timescale 1ns/1ps
module pt32_prescale
   import pt32_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic ext_src,
   input wire logic gated,
   input wire logic gate_lvl,
   input wire logic ext_rise,
   input wire logic [1:0] ps_sel,
   output logic tick
);

   logic [PT32_PSW-1:0] ps_cnt;
   wire logic base_evt;
   wire logic ps_done;

   // external counting always goes through the synchronised edge;
   // gate only qualifies the internal clock
   assign base_evt = ext_src ? ext_rise : (!gated || gate_lvl);
   assign ps_done = (ps_cnt == pt32_ps_limit(ps_sel));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ps_cnt <= PT32_PS_RST;
         tick <= 1'b0;
      end else begin
         tick <= run && base_evt && ps_done;
         if (!run) begin
            ps_cnt <= PT32_PS_RST;
         end else if (base_evt) begin
            ps_cnt <= ps_done ? PT32_PS_RST : ps_cnt + 8'h01;
         end
      end
   end

endmodule

// ===== hw/pt32_count.sv
// one 16-bit count half with wrap and period event
`timescale 1ns/1ps
module pt32_count
   import pt32_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   pt32_cnt_if.cnt cif
);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cif.count <= PT32_COUNT_RST;
         cif.evt <= 1'b0;
      end else begin
         cif.evt <= cif.inc && cif.wrap && cif.report;
         if (cif.inc) begin
            cif.count <= cif.wrap ? PT32_COUNT_RST : cif.count + 16'h0001;
         end
      end
   end

endmodule

// ===== dv/pt32_chk_sva.sv
// property checks on the paired timer top ports
`timescale 1ns/1ps
module pt32_chk_sva
   import pt32_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic idle,
   input wire logic [3:0] ctl_gated,
   input wire logic [3:0] ctl_ext,
   input wire logic [3:0] ctl_join,
   input wire logic [3:0] ctl_stop_idle,
   input wire logic [3:0] gate_pin,
   input wire logic [63:0] count,
   input wire logic [3:0] period_evt,
   input wire logic [3:0] dma_req,
   input wire logic adc_trig,
   input wire logic [3:0] tb_tick
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence join1_held;
      ctl_join[0] [*3];
   endsequence
   // seven cycles covers the gate synchroniser and the registered tick
   sequence gate3_shut;
      (ctl_gated[3] && !ctl_ext[3] && !gate_pin[3] && !ctl_join[2]) [*7];
   endsequence
   dma_eq_a: assert property (dma_req == period_evt)
      else $error("dma request differs from period event");
   adc_src_a: assert property (adc_trig |-> period_evt[1] && $past(ctl_join[0]))
      else $error("converter trigger without joined pair one event");
   evt_zero_a: assert property (period_evt[0] |-> count[15:0] == 16'h0000)
      else $error("event while count not zero");
   lo_silent_a: assert property (join1_held |-> !period_evt[0])
      else $error("lower half reported event while joined");
   hi_carry_a: assert property (join1_held ##0 (count[31:16] != $past(count[31:16])) |-> count[15:0] == 16'h0000)
      else $error("upper word moved without lower wrap");
   gate_hold_a: assert property (gate3_shut |-> $stable(count[63:48]))
      else $error("count moved with gate shut");
   idle_hold_a: assert property ((idle && ctl_stop_idle[3] && !ctl_join[2]) [*4] |-> $stable(count[63:48]))
      else $error("count moved while stopped in idle");
   step_one_a: assert property ($changed(count[63:48]) |->
      count[63:48] == $past(count[63:48]) + 16'h0001 || count[63:48] == 16'h0000)
      else $error("count jumped by more than one");
   tick_step_a: assert property ((!ctl_join[2] && $changed(count[63:48])) |-> tb_tick[3])
      else $error("count moved without a time base tick");
endmodule
bind pt32_top pt32_chk_sva u_chk (.clk(clk), .nrst(nrst), .idle(idle), .ctl_gated(ctl_gated), .ctl_ext(ctl_ext),
   .ctl_join(ctl_join), .ctl_stop_idle(ctl_stop_idle), .gate_pin(gate_pin), .count(count),
   .period_evt(period_evt), .dma_req(dma_req), .adc_trig(adc_trig), .tb_tick(tb_tick));

// ===== dv/pt32_tb.sv
// self-checking bench for the paired timer block
`timescale 1ns/1ps
module testbench
   import pt32_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic idle = 1'b0;
   logic [3:0] ctl_on = 4'h0, ctl_gated = 4'h0, ctl_ext = 4'h0, ctl_join = 4'h0, ctl_stop_idle = 4'h0;
   logic [7:0] ctl_ps = 8'h00;
   logic [63:0] period = 64'hFFFF_FFFF_0001_0002;
   logic [3:0] ext_clk_pin = 4'h0, gate_pin = 4'h0;
   logic [63:0] count;
   logic [3:0] period_evt, dma_req, tb_tick;
   logic adc_trig;
   int err_total = 0;
   int checks = 0;
   always #25 clk = ~clk;
   pt32_top dut (.clk(clk), .nrst(nrst), .idle(idle), .ctl_on(ctl_on), .ctl_gated(ctl_gated), .ctl_ext(ctl_ext),
      .ctl_join(ctl_join), .ctl_stop_idle(ctl_stop_idle), .ctl_ps(ctl_ps), .period(period),
      .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin), .count(count), .period_evt(period_evt),
      .dma_req(dma_req), .adc_trig(adc_trig), .tb_tick(tb_tick));
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // bounded so a dead timer ends the run instead of hanging it
   task automatic wait_evt(input int idx, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (period_evt[idx] !== 1'b1 && n < 70000);
      if (period_evt[idx] !== 1'b1) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
         report_and_stop();
      end
   endtask
   // advance of timer four over ten settled cycles
   task automatic adv(output logic [15:0] d);
      logic [15:0] c0;
      repeat (10) @(negedge clk);
      c0 = count[63:48];
      repeat (10) @(negedge clk);
      d = count[63:48] - c0;
   endtask
   task automatic t_walk();
      int n;
      @(posedge clk);
      ctl_on <= 4'h1;
      wait_evt(0, n);
      wait_evt(0, n);
      chk(32'(n), 32'h3);
      chk({16'h0, count[15:0]}, 32'h0);
      chk({28'h0, dma_req}, 32'h1);
      @(negedge clk);
      chk({16'h0, count[15:0]}, 32'h1);
      chk({28'h0, tb_tick}, 32'h1);
      $display("test walk done");
   endtask
   task automatic t_prescale();
      int n;
      int iv[4] = '{2, 16, 128, 512};
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         ctl_on <= 4'h3;
         ctl_ps <= 8'(s << 2);
         wait_evt(1, n);
         chk({31'h0, adc_trig}, 32'h0);
         wait_evt(1, n);
         chk(32'(n), 32'(iv[s]));
         chk({31'h0, dma_req[1]}, 32'h1);
      end
      $display("test prescale done");
   endtask
   task automatic t_hold();
      logic [15:0] d;
      logic [15:0] c0;
      @(posedge clk);
      ctl_on <= 4'h8;
      ctl_gated <= 4'h8;
      adv(d);
      chk({16'h0, d}, 32'h0);
      @(posedge clk);
      gate_pin <= 4'h8;
      adv(d);
      chk({16'h0, d}, 32'hA);
      @(posedge clk);
      idle <= 1'b1;
      ctl_stop_idle <= 4'h8;
      adv(d);
      chk({16'h0, d}, 32'h0);
      @(posedge clk);
      ctl_stop_idle <= 4'h0;
      adv(d);
      chk({16'h0, d}, 32'hA);
      @(posedge clk);
      idle <= 1'b0;
      ctl_ext <= 4'h8;
      adv(d);
      chk({16'h0, d}, 32'h0);
      c0 = count[63:48];
      for (int i = 0; i < 5; i++) begin
         repeat (3) @(posedge clk);
         ext_clk_pin <= 4'h8;
         repeat (3) @(posedge clk);
         ext_clk_pin <= 4'h0;
      end
      repeat (8) @(negedge clk);
      chk({16'h0, count[63:48] - c0}, 32'h5);
      $display("test hold done");
   endtask
   task automatic t_join();
      int n;
      @(posedge clk);
      ctl_on <= 4'h0;
      do_reset();
      ctl_on <= 4'h1;
      ctl_join <= 4'h1;
      ctl_gated <= 4'h2;
      period <= 64'hFFFF_FFFF_0001_0000;
      wait_evt(1, n);
      chk({31'h0, n > 65536}, 32'h1);
      chk(count[31:0], 32'h0);
      chk({31'h0, adc_trig}, 32'h1);
      chk({30'h0, period_evt[1:0]}, 32'h2);
      $display("test join done");
   endtask
   initial begin
      do_reset();
      t_walk();
      t_prescale();
      t_hold();
      t_join();
      report_and_stop();
   end
endmodule
